// File: hdl/lpw_pkg.sv
// Shared constants and types of the low-power mode and wake controller
package lpw_pkg;
  // ****************************************************
  // Register map
  // ****************************************************
  localparam int DATA_W = 8;
  localparam logic [7:0] ADDR_INT_OPT = 8'hC8;
  localparam logic [7:0] ADDR_CONV_CTRL = 8'hD1;
  localparam logic [7:0] ADDR_TIMER_CTRL = 8'hD4;
  localparam logic [7:0] ADDR_STATUS = 8'hE0;
  localparam logic [7:0] REG_RESET = 8'h00;
  // ****************************************************
  // Field positions
  // ****************************************************
  localparam int LES_BIT = 6;
  localparam int ESB_BIT = 5;
  localparam int GEN_BIT = 4;
  localparam int TMZ_BIT = 7;
  localparam int ETI_BIT = 6;
  localparam int EOC_BIT = 6;
  localparam int EAI_BIT = 5;
  // ****************************************************
  // Vectors, modes, contexts, timing
  // ****************************************************
  localparam logic [2:0] VEC_NMI = 3'h0;
  localparam logic [2:0] VEC_PORT_A = 3'h1;
  localparam logic [2:0] VEC_PORT_BC = 3'h2;
  localparam logic [2:0] VEC_TIMER = 3'h3;
  localparam logic [2:0] VEC_CONV = 3'h4;
  localparam int STAB_CYCLES_DEF = 2048;
  typedef enum logic [1:0] {
    LPW_RUN = 2'b00,
    LPW_WAIT = 2'b01,
    LPW_STOP = 2'b10,
    LPW_STAB = 2'b11
  } lpw_mode_t;
  typedef enum logic [1:0] {
    LPW_CTX_NORM = 2'b00,
    LPW_CTX_IRQ = 2'b01,
    LPW_CTX_NMI = 2'b10
  } lpw_ctx_t;
endpackage : lpw_pkg

// File: hdl/lpw_delay.sv
// Restart delay counter for the oscillator after stop mode
`timescale 1ns/1ps
`default_nettype none
module lpw_delay #(
  parameter int COUNT = 2048
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Control
  input wire logic start,
  output logic busy,
  output logic done
);
  import lpw_pkg::*;
  localparam int W = $clog2(COUNT + 1);
  logic [W-1:0] cnt;

  if (COUNT < 1) begin : g_chk
    $error("lpw_delay COUNT must be at least one");
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt <= '0;
      busy <= 1'b0;
    end else if (start) begin
      cnt <= W'(COUNT - 1);
      busy <= 1'b1;
    end else if (busy) begin
      if (cnt == '0) begin
        busy <= 1'b0;
      end else begin
        cnt <= cnt - 1'b1;
      end
    end
  end

  assign done = busy && (cnt == '0);
endmodule : lpw_delay
`default_nettype wire

// File: hdl/lpw_ctrl.sv
// Wait/stop mode sequencing, wake-up and interrupt dispatch for the core
`timescale 1ns/1ps
`default_nettype none
module lpw_ctrl #(
  parameter int PA_W = 8,
  parameter int PBC_W = 16,
  parameter int STAB_CYCLES = lpw_pkg::STAB_CYCLES_DEF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [lpw_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [lpw_pkg::DATA_W-1:0] reg_rdata,
  // Core sequencer
  input wire logic sleep_wait,
  input wire logic sleep_stop,
  input wire logic core_reti,
  input wire logic irq_ack,
  output logic irq_req,
  output logic [2:0] irq_vec,
  output logic core_halt,
  output lpw_pkg::lpw_ctx_t core_ctx,
  // Power state
  output logic osc_run,
  output lpw_pkg::lpw_mode_t mode_state,
  // Watchdog state
  input wire logic hw_wdg_sel,
  input wire logic sw_wdg_en,
  // Interrupt sources
  input wire logic nmi_pin_n,
  input wire logic [PA_W-1:0] pa_pin,
  input wire logic [PA_W-1:0] pa_irq_en,
  input wire logic [PBC_W-1:0] pbc_pin,
  input wire logic [PBC_W-1:0] pbc_irq_en,
  input wire logic timer_ovf,
  input wire logic conv_eoc
);
  import lpw_pkg::*;

  if (PA_W < 1 || PBC_W < 1 || STAB_CYCLES < 1) begin : g_chk
    $error("lpw_ctrl widths and delay must be at least one");
  end

  lpw_mode_t mode;
  lpw_mode_t next_mode;
  lpw_ctx_t ctx;
  lpw_ctx_t ctx_saved;
  logic les, esb, gen;
  logic timer_irq_en, timer_overflow_flag;
  logic conv_irq_en, conv_eoc_flag;
  logic nmi_s1, nmi_s2, nmi_d, nmi_lat;
  logic [PA_W-1:0] pa_s1, pa_s2;
  logic [PBC_W-1:0] pbc_s1, pbc_s2;
  logic a_line, a_line_d, a_lat;
  logic bc_line, bc_line_d, bc_lat, bc_edge;
  logic v1_req, v2_req, v3_req, v4_req;
  logic wake_any, stop_wake, wdg_on, take;
  logic stab_start, stab_done;

  // ****************************************************
  // Pin synchronisers and edge detection
  // ****************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      nmi_s1 <= 1'b1;
      nmi_s2 <= 1'b1;
      nmi_d <= 1'b1;
      pa_s1 <= '1;
      pa_s2 <= '1;
      pbc_s1 <= '1;
      pbc_s2 <= '1;
      a_line_d <= 1'b1;
      bc_line_d <= 1'b1;
    end else begin
      nmi_s1 <= nmi_pin_n;
      nmi_s2 <= nmi_s1;
      nmi_d <= nmi_s2;
      pa_s1 <= pa_pin;
      pa_s2 <= pa_s1;
      pbc_s1 <= pbc_pin;
      pbc_s2 <= pbc_s1;
      a_line_d <= a_line;
      bc_line_d <= bc_line;
    end
  end

  // Disabled pins are forced high so they never pull the wired line
  assign a_line = &(pa_s2 | ~pa_irq_en);
  assign bc_line = &(pbc_s2 | ~pbc_irq_en);
  assign bc_edge = esb ? (~bc_line_d & bc_line) : (bc_line_d & ~bc_line);

  // ****************************************************
  // Request latches
  // ****************************************************
  assign take = irq_req && irq_ack;

  // Set wins over the clear taken at routine entry
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      nmi_lat <= 1'b0;
      a_lat <= 1'b0;
      bc_lat <= 1'b0;
    end else begin
      nmi_lat <= (nmi_d & ~nmi_s2) | (nmi_lat & ~(take && irq_vec == VEC_NMI));
      a_lat <= ~les & ((a_line_d & ~a_line) | (a_lat & ~(take && irq_vec == VEC_PORT_A)));
      bc_lat <= bc_edge | (bc_lat & ~(take && irq_vec == VEC_PORT_BC));
    end
  end

  // Level mode keeps no memory: the pin must still be low when sampled
  assign v1_req = gen & (les ? ~a_line : a_lat);
  assign v2_req = gen & bc_lat;
  assign v3_req = gen & timer_irq_en & timer_overflow_flag;
  assign v4_req = gen & conv_irq_en & conv_eoc_flag;

  // ****************************************************
  // Wake decisions
  // ****************************************************
  assign wake_any = (gen & nmi_lat) | v1_req | v2_req | v3_req | v4_req;
  assign stop_wake = (gen & nmi_lat) | v1_req | v2_req;
  assign wdg_on = hw_wdg_sel | sw_wdg_en;

  // ****************************************************
  // Mode sequencing
  // ****************************************************
  always_comb begin
    next_mode = mode;
    unique case (mode)
      LPW_RUN: begin
        if (sleep_stop && !wake_any) begin
          next_mode = wdg_on ? LPW_WAIT : LPW_STOP;
        end else if (sleep_wait && !wake_any) begin
          next_mode = LPW_WAIT;
        end
      end
      LPW_WAIT: begin
        if (wake_any) begin
          next_mode = LPW_RUN;
        end
      end
      LPW_STOP: begin
        if (stop_wake) begin
          next_mode = LPW_STAB;
        end
      end
      LPW_STAB: begin
        if (stab_done) begin
          next_mode = LPW_RUN;
        end
      end
    endcase
  end

  assign stab_start = (mode == LPW_STOP) && stop_wake;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode <= LPW_RUN;
      osc_run <= 1'b1;
    end else begin
      mode <= next_mode;
      // Only stop gates the clock; wait keeps it for peripherals
      osc_run <= (next_mode != LPW_STOP);
    end
  end

  lpw_delay #(
    .COUNT(STAB_CYCLES)
  ) u_stab (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(stab_start),
    .busy(),
    .done(stab_done)
  );

  // Clock source choice stays outside; wake only flips the run gate
  assign core_halt = (mode != LPW_RUN);
  assign mode_state = mode;
  assign core_ctx = ctx;

  // ****************************************************
  // Dispatch and context
  // ****************************************************
  // Resumption after wake falls out of the context gating below
  always_comb begin
    irq_req = 1'b0;
    irq_vec = VEC_NMI;
    if (mode == LPW_RUN) begin
      if (nmi_lat && ctx != LPW_CTX_NMI) begin
        irq_req = 1'b1;
      end else if (ctx == LPW_CTX_NORM) begin
        irq_req = v1_req | v2_req | v3_req | v4_req;
        if (v1_req) begin
          irq_vec = VEC_PORT_A;
        end else if (v2_req) begin
          irq_vec = VEC_PORT_BC;
        end else if (v3_req) begin
          irq_vec = VEC_TIMER;
        end else if (v4_req) begin
          irq_vec = VEC_CONV;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctx <= LPW_CTX_NORM;
      ctx_saved <= LPW_CTX_NORM;
    end else if (take) begin
      if (irq_vec == VEC_NMI) begin
        ctx_saved <= ctx;
        ctx <= LPW_CTX_NMI;
      end else begin
        ctx <= LPW_CTX_IRQ;
      end
    end else if (core_reti) begin
      unique case (ctx)
        LPW_CTX_NMI: ctx <= ctx_saved;
        LPW_CTX_IRQ: ctx <= LPW_CTX_NORM;
        LPW_CTX_NORM: ctx <= LPW_CTX_NORM;
        default: ctx <= LPW_CTX_NORM;
      endcase
    end
  end

  // ****************************************************
  // Register port
  // ****************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      les <= 1'b0;
      esb <= 1'b0;
      gen <= 1'b0;
    end else if (reg_wr && reg_addr == ADDR_INT_OPT) begin
      les <= reg_wdata[LES_BIT];
      esb <= reg_wdata[ESB_BIT];
      gen <= reg_wdata[GEN_BIT];
    end
  end

  // Flags clear on a written zero; a new event in that cycle wins
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      timer_irq_en <= 1'b0;
      timer_overflow_flag <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == ADDR_TIMER_CTRL) begin
        timer_irq_en <= reg_wdata[ETI_BIT];
      end
      timer_overflow_flag <= timer_ovf | (timer_overflow_flag
        & ~(reg_wr && reg_addr == ADDR_TIMER_CTRL && !reg_wdata[TMZ_BIT]));
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      conv_irq_en <= 1'b0;
      conv_eoc_flag <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == ADDR_CONV_CTRL) begin
        conv_irq_en <= reg_wdata[EAI_BIT];
      end
      conv_eoc_flag <= conv_eoc | (conv_eoc_flag
        & ~(reg_wr && reg_addr == ADDR_CONV_CTRL && !reg_wdata[EOC_BIT]));
    end
  end

  // Option register is write-only and reads back as zero
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= REG_RESET;
    end else begin
      reg_rdata <= REG_RESET;
      if (reg_rd) begin
        unique case (reg_addr)
          ADDR_TIMER_CTRL: begin
            reg_rdata[TMZ_BIT] <= timer_overflow_flag;
            reg_rdata[ETI_BIT] <= timer_irq_en;
          end
          ADDR_CONV_CTRL: begin
            reg_rdata[EOC_BIT] <= conv_eoc_flag;
            reg_rdata[EAI_BIT] <= conv_irq_en;
          end
          ADDR_STATUS: reg_rdata <= {mode, ctx, nmi_lat, a_lat, bc_lat, stab_done};
          default: reg_rdata <= REG_RESET;
        endcase
      end
    end
  end

  // ****************************************************
  // Checks
  // ****************************************************
  localparam int SL_W = $clog2(STAB_CYCLES + 1);
  logic [SL_W-1:0] stab_len;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stab_len <= '0;
    end else begin
      stab_len <= (mode == LPW_STAB) ? stab_len + 1'b1 : '0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_gen_gates_mask: assert property (irq_req && irq_vec != VEC_NMI |-> gen)
    else $error("maskable request without global enable");
  chk_timer_vector: assert property (irq_req && irq_vec == VEC_TIMER
      |-> timer_irq_en && timer_overflow_flag && !v1_req && !v2_req)
    else $error("timer vector without enabled flag");
  chk_wait_entry: assert property (mode == LPW_RUN && sleep_wait && !sleep_stop
      && !wake_any |=> mode == LPW_WAIT && core_halt && osc_run)
    else $error("wait entry wrong");
  chk_wait_osc_on: assert property (mode == LPW_WAIT |-> osc_run)
    else $error("oscillator stopped in wait");
  chk_wait_exit_fast: assert property (mode == LPW_WAIT && wake_any
      |=> mode == LPW_RUN && !core_halt)
    else $error("wait exit delayed");
  chk_stop_osc_off: assert property ($past(mode) == LPW_STOP && mode == LPW_STOP
      |-> !osc_run)
    else $error("oscillator running in stop");
  chk_stab_length: assert property (mode == LPW_STAB && stab_done
      |-> stab_len == SL_W'(STAB_CYCLES - 1) ##1 mode == LPW_RUN)
    else $error("stabilisation length wrong");
  chk_wdg_stop_wait: assert property (mode == LPW_RUN && sleep_stop && wdg_on
      && !wake_any |=> mode == LPW_WAIT)
    else $error("stop taken with watchdog on");
  chk_pending_blocks: assert property (mode == LPW_RUN && wake_any
      |=> mode == LPW_RUN)
    else $error("sleep entered with pending request");
  chk_no_nesting: assert property (irq_req && irq_vec != VEC_NMI
      |-> ctx == LPW_CTX_NORM)
    else $error("maskable request nested");
  chk_nmi_no_wake: assert property (mode == LPW_WAIT && !gen |=> mode == LPW_WAIT [*2])
    else $error("woke with global enable clear");

  cov_wait_wake: cover property (mode == LPW_WAIT ##1 mode == LPW_RUN);
  cov_stop_restart: cover property (mode == LPW_STOP ##1 mode == LPW_STAB);
  cov_nmi_in_irq: cover property (take && irq_vec == VEC_NMI && ctx == LPW_CTX_IRQ);
  cov_timer_take: cover property (take && irq_vec == VEC_TIMER);
endmodule : lpw_ctrl
`default_nettype wire

// File: verification/lpw_core_model.sv
// Core sequencer model that acknowledges interrupt requests and logs vectors
`timescale 1ns/1ps
`default_nettype none
module lpw_core_model (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Dispatch
  input wire logic irq_req,
  input wire logic [2:0] irq_vec,
  input wire logic ack_en,
  output logic irq_ack,
  // Log
  output logic [7:0] ack_cnt,
  output logic [2:0] last_vec
);
  // ****************************
  // Acknowledge
  // ****************************
  // One cycle late, like a core ending its instruction; held off by ack_en
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_ack <= 1'b0;
      ack_cnt <= 8'h00;
      last_vec <= 3'h7;
    end else begin
      if (irq_ack && irq_req) begin
        ack_cnt <= ack_cnt + 8'h01;
        last_vec <= irq_vec;
      end
      irq_ack <= ack_en && irq_req && !irq_ack;
    end
  end
endmodule : lpw_core_model
`default_nettype wire

// File: verification/testbench.sv
// Self-checking bench for the low-power mode and wake controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import lpw_pkg::*;
  localparam int STAB = 6;
  logic clk, sys_rst, reg_wr, reg_rd, sleep_wait, sleep_stop, core_reti, irq_ack, irq_req;
  logic core_halt, osc_run, hw_wdg_sel, sw_wdg_en, nmi_pin_n, timer_ovf, conv_eoc, ack_en;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, pa_pin, pa_irq_en, ack_cnt;
  logic [15:0] pbc_pin, pbc_irq_en;
  logic [2:0] irq_vec, last_vec;
  lpw_ctx_t core_ctx;
  lpw_mode_t mode_state;
  int mismatches, checks_done, n;
  // ****************************
  // Design and core model
  // ****************************
  lpw_ctrl #(.PA_W(8), .PBC_W(16), .STAB_CYCLES(STAB)) dut (.clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sleep_wait(sleep_wait), .sleep_stop(sleep_stop),
    .core_reti(core_reti), .irq_ack(irq_ack), .irq_req(irq_req), .irq_vec(irq_vec),
    .core_halt(core_halt), .core_ctx(core_ctx), .osc_run(osc_run), .mode_state(mode_state),
    .hw_wdg_sel(hw_wdg_sel), .sw_wdg_en(sw_wdg_en), .nmi_pin_n(nmi_pin_n), .pa_pin(pa_pin),
    .pa_irq_en(pa_irq_en), .pbc_pin(pbc_pin), .pbc_irq_en(pbc_irq_en),
    .timer_ovf(timer_ovf), .conv_eoc(conv_eoc));
  lpw_core_model core (.clk(clk), .sys_rst(sys_rst), .irq_req(irq_req), .irq_vec(irq_vec),
    .ack_en(ack_en), .irq_ack(irq_ack), .ack_cnt(ack_cnt), .last_vec(last_vec));
  always #4 clk = ~clk;
  // ****************************
  // Tasks
  // ****************************
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk("rdata", e, reg_rdata);
  endtask : rd
  // Pulse order: wait, stop, reti, timer, converter
  task automatic go(input logic [4:0] m);
    @(posedge clk);
    {sleep_wait, sleep_stop, core_reti, timer_ovf, conv_eoc} <= m;
    @(posedge clk);
    {sleep_wait, sleep_stop, core_reti, timer_ovf, conv_eoc} <= 5'h00;
  endtask : go
  task automatic md(input logic [1:0] m);
    #1;
    chk("mode", {6'h00, m}, {6'h00, mode_state});
  endtask : md
  // Context and acknowledge counts update at the edge, so look after it
  task automatic cx(input logic [1:0] c);
    #1;
    chk("ctx", {6'h00, c}, {6'h00, core_ctx});
  endtask : cx
  task automatic ack_is(input logic [7:0] c, input logic [7:0] v);
    #1;
    chk("acks", c, ack_cnt);
    chk("vec", v, {5'h00, last_vec});
  endtask : ack_is
  // Clear the timer flag, keep its enable, and leave the routine
  task automatic tmr_done;
    wr(ADDR_TIMER_CTRL, 8'h40);
    go(5'h04);
  endtask : tmr_done
  task automatic wait_mode(input logic [1:0] m, input int lim);
    #1;
    n = 0;
    while (mode_state !== m && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("mode", {6'h00, m}, {6'h00, mode_state});
    if (mode_state !== m) final_report();
  endtask : wait_mode
  // ****************************
  // Sequence
  // ****************************
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    {reg_wr, reg_rd, sleep_wait, sleep_stop, core_reti, timer_ovf, conv_eoc} = 7'h00;
    {hw_wdg_sel, sw_wdg_en} = 2'b00;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    nmi_pin_n = 1'b1;
    pa_pin = 8'hFF;
    pa_irq_en = 8'h01;
    pbc_pin = 16'hFFFF;
    pbc_irq_en = 16'h0100;
    ack_en = 1'b1;
    mismatches = 0;
    checks_done = 0;
    tick(4);
    sys_rst <= 1'b0;
    md(LPW_RUN);
    chk("osc", 8'h01, {7'h00, osc_run});
    rd(ADDR_INT_OPT, 8'h00);
    rd(8'h55, 8'h00);
    rd(ADDR_STATUS, 8'h00);
    wr(ADDR_TIMER_CTRL, 8'h40);
    go(5'h02);
    tick(3);
    chk("acks", 8'h00, ack_cnt);
    rd(ADDR_TIMER_CTRL, 8'hC0);
    wr(ADDR_INT_OPT, 8'h10);
    tick(3);
    ack_is(8'h01, 8'h03);
    cx(LPW_CTX_IRQ);
    tmr_done();
    wr(ADDR_CONV_CTRL, 8'h20);
    go(5'h01);
    tick(3);
    ack_is(8'h02, 8'h04);
    rd(ADDR_CONV_CTRL, 8'h60);
    wr(ADDR_CONV_CTRL, 8'h20);
    go(5'h04);
    // Both pending while disabled, then released together
    wr(ADDR_INT_OPT, 8'h00);
    go(5'h03);
    wr(ADDR_INT_OPT, 8'h10);
    tick(8);
    ack_is(8'h03, 8'h03);
    tmr_done();
    tick(3);
    ack_is(8'h04, 8'h04);
    wr(ADDR_CONV_CTRL, 8'h20);
    go(5'h04);
    // Sleep refused while a request waits unacknowledged
    @(posedge clk) ack_en <= 1'b0;
    go(5'h02);
    go(5'h10);
    md(LPW_RUN);
    @(posedge clk) ack_en <= 1'b1;
    tick(3);
    ack_is(8'h05, 8'h03);
    tmr_done();
    go(5'h10);
    md(LPW_WAIT);
    chk("halt", 8'h01, {7'h00, core_halt});
    chk("osc", 8'h01, {7'h00, osc_run});
    go(5'h02);
    wait_mode(LPW_RUN, 2);
    tick(3);
    ack_is(8'h06, 8'h03);
    tmr_done();
    for (int w = 0; w < 2; w++) begin
      @(posedge clk) {hw_wdg_sel, sw_wdg_en} <= (w == 0) ? 2'b10 : 2'b01;
      go(5'h08);
      md(LPW_WAIT);
      chk("osc", 8'h01, {7'h00, osc_run});
      go(5'h02);
      wait_mode(LPW_RUN, 2);
      tick(3);
      tmr_done();
    end
    @(posedge clk) {hw_wdg_sel, sw_wdg_en} <= 2'b00;
    go(5'h08);
    md(LPW_STOP);
    chk("osc", 8'h00, {7'h00, osc_run});
    go(5'h02);
    tick(4);
    md(LPW_STOP);
    @(posedge clk) pa_pin <= 8'hFE;
    wait_mode(LPW_STAB, 8);
    chk("osc", 8'h01, {7'h00, osc_run});
    n = 0;
    while (mode_state === LPW_STAB && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("stab", 8'(STAB), n[7:0]);
    if (mode_state === LPW_STAB) begin
      final_report();
    end
    tick(2);
    ack_is(8'h09, 8'h01);
    @(posedge clk) pa_pin <= 8'hFF;
    go(5'h04);
    tick(3);
    ack_is(8'h0A, 8'h03);
    tmr_done();
    @(posedge clk) pbc_pin <= 16'hFEFF;
    tick(6);
    ack_is(8'h0B, 8'h02);
    @(posedge clk) pbc_pin <= 16'hFFFF;
    go(5'h04);
    // Sleep inside the non-maskable routine
    @(posedge clk) nmi_pin_n <= 1'b0;
    tick(7);
    ack_is(8'h0C, 8'h00);
    @(posedge clk) nmi_pin_n <= 1'b1;
    go(5'h10);
    go(5'h02);
    wait_mode(LPW_RUN, 2);
    tick(3);
    chk("acks", 8'h0C, ack_cnt);
    cx(LPW_CTX_NMI);
    tmr_done();
    cx(LPW_CTX_NORM);
    // Sleep inside a normal routine
    go(5'h02);
    tick(3);
    wr(ADDR_TIMER_CTRL, 8'h40);
    go(5'h10);
    go(5'h02);
    wait_mode(LPW_RUN, 2);
    tick(3);
    chk("acks", 8'h0D, ack_cnt);
    cx(LPW_CTX_IRQ);
    wr(ADDR_TIMER_CTRL, 8'h40);
    go(5'h10);
    md(LPW_WAIT);
    @(posedge clk) nmi_pin_n <= 1'b0;
    wait_mode(LPW_RUN, 8);
    tick(3);
    ack_is(8'h0E, 8'h00);
    @(posedge clk) nmi_pin_n <= 1'b1;
    go(5'h04);
    #1;
    cx(LPW_CTX_IRQ);
    go(5'h04);
    // Level mode on port A re-requests while low; ports B and C on rising edge
    wr(ADDR_INT_OPT, 8'h70);
    @(posedge clk) pa_pin <= 8'hFE;
    tick(5);
    ack_is(8'h0F, 8'h01);
    go(5'h04);
    tick(3);
    ack_is(8'h10, 8'h01);
    @(posedge clk) pa_pin <= 8'hFF;
    tick(2);
    go(5'h04);
    @(posedge clk) pbc_pin <= 16'hFEFF;
    tick(6);
    chk("acks", 8'h10, ack_cnt);
    @(posedge clk) pbc_pin <= 16'hFFFF;
    tick(6);
    ack_is(8'h11, 8'h02);
    go(5'h04);
    // Disabled: non-maskable pin cannot wake, only reset
    wr(ADDR_INT_OPT, 8'h00);
    go(5'h10);
    @(posedge clk) nmi_pin_n <= 1'b0;
    tick(8);
    md(LPW_WAIT);
    @(posedge clk) nmi_pin_n <= 1'b1;
    tick(4);
    @(posedge clk) sys_rst <= 1'b1;
    tick(2);
    sys_rst <= 1'b0;
    md(LPW_RUN);
    chk("halt", 8'h00, {7'h00, core_halt});
    final_report();
  end
endmodule : testbench
`default_nettype wire
